// ### suv_regs.vh
// Register map, field positions and timing constants of the supply supervisor
// Notes on behaviour
// R1: A supply drop below the warning level sets the warning event and, unless masked, pulls interrupt_request_n low.
// R2: The host clears the warning event, and interrupt_request_n is released once no unmasked event remains.
// R3: After the supply rises back above the warning level a 1 s debounce runs before monitoring resumes.
// R4: While that debounce runs the comparators are ignored, so a new drop raises no event.
// R5: A drop below supply_error_threshold sets the supply fault flag and starts a shutdown.
// R6: The error shutdown steps down like a normal power-down but ends in RESET instead of POWERDOWN.
// R7: Finishing the error shutdown clears the retry counter and leaves the fault flag set.
// R8: The sequencer stays in RESET while the supply is below the error level, then runs a cold boot.
// R9: Once started, the host reads and writes the registers for configuration and interrupt service.
// R10: During power-down host_reboot_n is asserted and supplies switch off in reverse power-up order.
// R11: Successive supply steps are spaced 2 ms apart when powering up and down.
// R12: The warning event stays set until the host clears it, whatever the supply does meanwhile.
`ifndef SUV_REGS_VH
`define SUV_REGS_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define SUV_ADDR_EVENT 8'h00
`define SUV_ADDR_MASK 8'h04
`define SUV_ADDR_FAULT 8'h08
`define SUV_ADDR_CTRL 8'h0c
`define SUV_ADDR_STATUS 8'h10
`define SUV_ADDR_RETRY 8'h14

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define SUV_CTRL_RST 1'b1
`define SUV_MASK_RST 1'b0
`define SUV_CMP_RST 2'h2
`define SUV_RETRY_RST 4'h0
`define SUV_ST_RETRY_LSB 8
`define SUV_ST_DB_BIT 16
`define SUV_LAST_SUP 2'h3
`define SUV_FIRST_SUP 2'h0
`define SUV_RESP_OKAY 2'h0
`define SUV_RESP_SLVERR 2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SUV_CLK_HZ 50000000
`define SUV_DEBOUNCE_S 1
`define SUV_STEP_MS 2

`endif

// ### suv_sync.v
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/10ps
module suv_sync #(
   parameter W = 1,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   input wire aclk, // Clock
   input wire aresetn, // Synchronous reset, active low
   input wire [W-1:0] d, // Asynchronous levels
   output reg [W-1:0] q // Synchronised levels
);
   reg [W-1:0] meta_q;

   always @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule // suv_sync

// ### suv_supervisor.v
// Supply undervoltage supervisor with power sequencer and AXI4-Lite registers
`timescale 1ns/10ps
`include "suv_regs.vh"
module suv_supervisor #(
   parameter DEBOUNCE_CYCLES = `SUV_DEBOUNCE_S * `SUV_CLK_HZ,
   parameter STEP_CYCLES = `SUV_STEP_MS * (`SUV_CLK_HZ / 1000)
) (
   input wire aclk, // Clock, 50 MHz
   input wire aresetn, // Synchronous reset, active low
   input wire awvalid, // Write address valid
   output reg awready, // Write address ready
   input wire [7:0] awaddr, // Write byte address
   input wire wvalid, // Write data valid
   output reg wready, // Write data ready
   input wire [31:0] wdata, // Write data
   input wire [3:0] wstrb, // Write byte strobes
   output reg bvalid, // Write response valid
   input wire bready, // Write response ready
   output reg [1:0] bresp, // Write response
   input wire arvalid, // Read address valid
   output reg arready, // Read address ready
   input wire [7:0] araddr, // Read byte address
   output reg rvalid, // Read data valid
   input wire rready, // Read data ready
   output reg [31:0] rdata, // Read data
   output reg [1:0] rresp, // Read response
   input wire supply_below_warn, // Comparator: supply under warning level
   input wire supply_error_threshold, // Comparator: supply under error level
   output reg [3:0] supply_en, // Supply rail enables
   output reg host_reboot_n, // Host reboot, active low
   output reg interrupt_request_n // Interrupt, active low
);
   // ----------------------------------------------------------------------
   // Sequencer modes
   // ----------------------------------------------------------------------
   localparam [4:0] ST_RESET = 5'h01;
   localparam [4:0] ST_UP = 5'h02;
   localparam [4:0] ST_ACTIVE = 5'h04;
   localparam [4:0] ST_DOWN = 5'h08;
   localparam [4:0] ST_OFF = 5'h10;

   reg [4:0] st_q;
   reg [1:0] idx_q;
   reg to_reset_q;
   reg [31:0] step_cnt_q;
   reg [3:0] retry_q;
   reg ctrl_en_q;
   reg mask_q;
   reg ev_warn_q;
   reg fault_q;
   reg warn_low_q;
   reg db_active_q;
   reg [31:0] db_cnt_q;
   reg aw_held_q;
   reg w_held_q;
   reg [7:0] wr_addr_q;
   reg [31:0] wr_data_q;
   reg [3:0] wr_strb_q;
   reg [31:0] rd_mux;
   reg rd_ok;
   wire warn_s;
   wire err_s;
   wire [1:0] cmp_s;

   // ----------------------------------------------------------------------
   // Comparator synchronisation
   // ----------------------------------------------------------------------
   // Error resets to "low supply" so nothing sequences until the levels are
   // real; warning resets to "good" so leaving reset raises no false event.
   suv_sync #(.W(2), .RST_VAL(`SUV_CMP_RST)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({supply_error_threshold, supply_below_warn}),
      .q(cmp_s)
   );
   assign warn_s = cmp_s[0];
   assign err_s = cmp_s[1];

   // ----------------------------------------------------------------------
   // Register access strobes
   // ----------------------------------------------------------------------
   wire do_wr = aw_held_q & w_held_q & ~bvalid;
   wire wr_lo = do_wr & wr_strb_q[0];
   wire wr_ev = wr_lo & (wr_addr_q == `SUV_ADDR_EVENT);
   wire wr_mask = wr_lo & (wr_addr_q == `SUV_ADDR_MASK);
   wire wr_fault = wr_lo & (wr_addr_q == `SUV_ADDR_FAULT);
   wire wr_ctrl = wr_lo & (wr_addr_q == `SUV_ADDR_CTRL);
   wire wr_retry = wr_lo & (wr_addr_q == `SUV_ADDR_RETRY);
   wire ar_hs = arvalid & arready;
   wire rd_ev = ar_hs & (araddr == `SUV_ADDR_EVENT);
   wire wr_known = (wr_addr_q == `SUV_ADDR_EVENT) | (wr_addr_q == `SUV_ADDR_MASK) |
                   (wr_addr_q == `SUV_ADDR_FAULT) | (wr_addr_q == `SUV_ADDR_CTRL) |
                   (wr_addr_q == `SUV_ADDR_STATUS) | (wr_addr_q == `SUV_ADDR_RETRY);

   // ----------------------------------------------------------------------
   // Supply monitor
   // ----------------------------------------------------------------------
   wire mon_on = ~db_active_q; // R4
   wire warn_set = mon_on & warn_s & ~warn_low_q; // R1
   wire seq_on = (st_q == ST_UP) | (st_q == ST_ACTIVE);
   wire err_set = mon_on & err_s & seq_on; // R5

   always @(posedge aclk) begin
      if (!aresetn) begin
         warn_low_q <= 1'b0;
         db_active_q <= 1'b0;
         db_cnt_q <= 32'h0;
      end else if (warn_set) begin
         warn_low_q <= 1'b1;
      end else if (warn_low_q & ~warn_s) begin
         warn_low_q <= 1'b0;
         db_active_q <= 1'b1; // R3
         db_cnt_q <= DEBOUNCE_CYCLES - 1; // R3
      end else if (db_active_q) begin
         if (db_cnt_q == 32'h0) begin
            db_active_q <= 1'b0;
         end else begin
            db_cnt_q <= db_cnt_q - 32'h1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Event, mask, fault and control registers
   // ----------------------------------------------------------------------
   // A new warning in the same cycle as a clear keeps the bit set.
   always @(posedge aclk) begin
      if (!aresetn) begin
         ev_warn_q <= 1'b0;
         fault_q <= 1'b0;
         mask_q <= `SUV_MASK_RST;
         ctrl_en_q <= `SUV_CTRL_RST;
         interrupt_request_n <= 1'b1;
      end else begin
         ev_warn_q <= warn_set | (ev_warn_q & ~((wr_ev & wr_data_q[0]) | rd_ev)); // R12
         fault_q <= err_set | (fault_q & ~(wr_fault & wr_data_q[0])); // R7
         if (wr_mask) begin
            mask_q <= wr_data_q[0]; // R9
         end
         if (st_q == ST_RESET) begin
            ctrl_en_q <= `SUV_CTRL_RST;
         end else if (wr_ctrl) begin
            ctrl_en_q <= wr_data_q[0]; // R9
         end
         interrupt_request_n <= ~(ev_warn_q & ~mask_q); // R1 R2
      end
   end

   // ----------------------------------------------------------------------
   // Power sequencer
   // ----------------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= ST_RESET;
         idx_q <= `SUV_FIRST_SUP;
         to_reset_q <= 1'b0;
         step_cnt_q <= 32'h0;
         retry_q <= `SUV_RETRY_RST;
         supply_en <= 4'h0;
         host_reboot_n <= 1'b0;
      end else begin
         if (wr_retry) begin
            retry_q <= wr_data_q[3:0];
         end
         case (st_q)
            ST_RESET: begin
               supply_en <= 4'h0;
               host_reboot_n <= 1'b0;
               if (!err_s) begin
                  st_q <= ST_UP; // R8
                  idx_q <= `SUV_FIRST_SUP;
                  step_cnt_q <= STEP_CYCLES - 1;
               end
            end
            ST_UP: begin
               host_reboot_n <= 1'b1;
               if (err_set) begin
                  st_q <= ST_DOWN; // R5
                  to_reset_q <= 1'b1;
                  idx_q <= `SUV_LAST_SUP;
                  step_cnt_q <= STEP_CYCLES - 1;
                  host_reboot_n <= 1'b0;
               end else if (step_cnt_q == 32'h0) begin
                  supply_en <= supply_en | (4'h1 << idx_q);
                  if (idx_q == `SUV_LAST_SUP) begin
                     st_q <= ST_ACTIVE;
                  end else begin
                     idx_q <= idx_q + 2'h1;
                     step_cnt_q <= STEP_CYCLES - 1; // R11
                  end
               end else begin
                  step_cnt_q <= step_cnt_q - 32'h1;
               end
            end
            ST_ACTIVE: begin
               if (err_set | ~ctrl_en_q) begin
                  st_q <= ST_DOWN;
                  to_reset_q <= err_set; // R6
                  idx_q <= `SUV_LAST_SUP; // R10
                  step_cnt_q <= STEP_CYCLES - 1;
                  host_reboot_n <= 1'b0; // R10
               end
            end
            ST_DOWN: begin
               host_reboot_n <= 1'b0; // R10
               if (step_cnt_q == 32'h0) begin
                  supply_en <= supply_en & ~(4'h1 << idx_q); // R10
                  if (idx_q == `SUV_FIRST_SUP) begin
                     if (to_reset_q) begin
                        st_q <= ST_RESET; // R6
                        retry_q <= `SUV_RETRY_RST; // R7
                     end else begin
                        st_q <= ST_OFF;
                     end
                  end else begin
                     idx_q <= idx_q - 2'h1;
                     step_cnt_q <= STEP_CYCLES - 1; // R11
                  end
               end else begin
                  step_cnt_q <= step_cnt_q - 32'h1;
               end
            end
            ST_OFF: begin
               host_reboot_n <= 1'b0;
               if (ctrl_en_q) begin
                  st_q <= ST_UP;
                  idx_q <= `SUV_FIRST_SUP;
                  step_cnt_q <= STEP_CYCLES - 1;
               end
            end
            default: begin
               st_q <= ST_RESET;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------------
   // Address and data are taken in either order; ready stays low until
   // the response is accepted, so one write is in flight at most.
   always @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         wr_addr_q <= 8'h0;
         wr_data_q <= 32'h0;
         wr_strb_q <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `SUV_RESP_OKAY;
      end else begin
         if (awvalid & awready) begin
            awready <= 1'b0;
            aw_held_q <= 1'b1;
            wr_addr_q <= awaddr;
         end
         if (wvalid & wready) begin
            wready <= 1'b0;
            w_held_q <= 1'b1;
            wr_data_q <= wdata;
            wr_strb_q <= wstrb;
         end
         if (do_wr) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_known ? `SUV_RESP_OKAY : `SUV_RESP_SLVERR;
         end
         if (bvalid & bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------------
   always @* begin
      rd_mux = 32'h0;
      rd_ok = 1'b1;
      case (araddr)
         `SUV_ADDR_EVENT: rd_mux = {31'h0, ev_warn_q};
         `SUV_ADDR_MASK: rd_mux = {31'h0, mask_q};
         `SUV_ADDR_FAULT: rd_mux = {31'h0, fault_q};
         `SUV_ADDR_CTRL: rd_mux = {31'h0, ctrl_en_q};
         `SUV_ADDR_STATUS: rd_mux = {27'h0, st_q} |
                                    ({28'h0, retry_q} << `SUV_ST_RETRY_LSB) |
                                    ({31'h0, db_active_q} << `SUV_ST_DB_BIT);
         `SUV_ADDR_RETRY: rd_mux = {28'h0, retry_q};
         default: rd_ok = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= `SUV_RESP_OKAY;
      end else begin
         if (ar_hs) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_mux; // R9
            rresp <= rd_ok ? `SUV_RESP_OKAY : `SUV_RESP_SLVERR;
         end else if (rvalid & rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end
endmodule // suv_supervisor

// ### suv_supervisor_props.sv
// Port assertions for the supply supervisor
`timescale 1ns/10ps
module suv_supervisor_props #(
   parameter STEP_CYCLES = 10
) (
   input logic aclk, // Clock
   input logic aresetn, // Reset, active low
   input logic awvalid, // Write address valid
   input logic awready, // Write address ready
   input logic wready, // Write data ready
   input logic bvalid, // Write response valid
   input logic arvalid, // Read address valid
   input logic arready, // Read address ready
   input logic rvalid, // Read data valid
   input logic [3:0] supply_en, // Rail enables
   input logic host_reboot_n, // Host reboot, active low
   input logic interrupt_request_n // Interrupt, active low
);
   logic [15:0] gap_q;
   logic [15:0] idle_q;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Counters saturate so the first step after a long pause never looks early
   always @(posedge aclk) begin
      if (!aresetn) begin
         gap_q <= 16'hffff;
         idle_q <= 16'hffff;
      end else begin
         gap_q <= (supply_en != $past(supply_en)) ? 16'h0 : gap_q + (gap_q != 16'hffff);
         idle_q <= (awvalid | arvalid) ? 16'h0 : idle_q + (idle_q != 16'hffff);
      end
   end
   property p_dn_order;
      supply_en < $past(supply_en) |-> supply_en == ($past(supply_en) >> 1);
   endproperty
   a_dn_order: assert property (p_dn_order) else $error("rails off out of order");
   property p_dn_reboot;
      supply_en < $past(supply_en) |-> !host_reboot_n;
   endproperty
   a_dn_reboot: assert property (p_dn_reboot) else $error("rail off with host running");
   property p_up_order;
      supply_en > $past(supply_en) |-> supply_en == (($past(supply_en) << 1) | 4'h1);
   endproperty
   a_up_order: assert property (p_up_order) else $error("rails on out of order");
   property p_up_boot;
      supply_en > $past(supply_en) |-> host_reboot_n && $past(host_reboot_n);
   endproperty
   a_up_boot: assert property (p_up_boot) else $error("rail on while host held");
   property p_step;
      supply_en != $past(supply_en) |-> gap_q >= STEP_CYCLES - 1;
   endproperty
   a_step: assert property (p_step) else $error("rail steps too close");
   property p_dn_start;
      $fell(host_reboot_n) && supply_en == 4'hf |-> ##[1:12] supply_en == 4'h7;
   endproperty
   a_dn_start: assert property (p_dn_start) else $error("shutdown did not step");
   property p_irq_rel;
      $rose(interrupt_request_n) |-> idle_q < 16'h4;
   endproperty
   a_irq_rel: assert property (p_irq_rel) else $error("interrupt released unasked");
   property p_bus_b;
      bvalid |-> !awready && !wready;
   endproperty
   a_bus_b: assert property (p_bus_b) else $error("write taken during response");
   property p_bus_r;
      rvalid |-> !arready;
   endproperty
   a_bus_r: assert property (p_bus_r) else $error("read taken during response");
endmodule // suv_supervisor_props

bind suv_supervisor suv_supervisor_props #(.STEP_CYCLES(STEP_CYCLES)) i_props (.aclk, .aresetn,
   .awvalid, .awready, .wready, .bvalid, .arvalid, .arready, .rvalid, .supply_en,
   .host_reboot_n, .interrupt_request_n);

// ### suv_supply_model.sv
// Supply rail model driving the two comparator levels
`timescale 1ns/10ps
module suv_supply_model (
   input logic [1:0] level, // 0 good, 1 under warning, 2 under error
   output logic below_warn, // Under warning level
   output logic below_err // Under error level
);
   // An error-level supply is always under the warning level too
   assign below_warn = (level != 2'h0);
   assign below_err = (level == 2'h2);
endmodule // suv_supply_model

// ### suv_supervisor_tb_top.sv
// Self-checking bench for the supply supervisor
`timescale 1ns/10ps
`include "suv_regs.vh"
module suv_supervisor_tb_top;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
   logic [7:0] awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] level = 2'h0;
   wire awready, wready, bvalid, arready, rvalid, host_reboot_n, interrupt_request_n;
   wire supply_below_warn, supply_error_threshold;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [3:0] supply_en;
   int error_cnt = 0, n_compared = 0, cyc = 0;
   suv_supervisor #(.DEBOUNCE_CYCLES(50), .STEP_CYCLES(10)) i_dut (.aclk, .aresetn, .awvalid,
      .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready(1'b1), .bresp,
      .arvalid, .arready, .araddr, .rvalid, .rready(1'b1), .rdata, .rresp, .supply_below_warn,
      .supply_error_threshold, .supply_en, .host_reboot_n, .interrupt_request_n);
   suv_supply_model i_sup (.level, .below_warn(supply_below_warn),
      .below_err(supply_error_threshold));
   initial begin
      forever #10 aclk = ~aclk;
   end
   // ----------------------------------------------------------------------
   // Checks and bus tasks
   // ----------------------------------------------------------------------
   task chk_reg(input string n, input logic [34:0] e, input logic [34:0] s);
      n_compared++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task chk_pin(input string n, input logic [3:0] e, input logic [3:0] s);
      n_compared++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      // Only the bench timeout ends a wait for the response
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      chk_reg("bresp", {1'b1, er, 32'h0}, {bvalid, bresp, 32'h0});
   endtask
   task rd(input string n, input logic [7:0] a, input logic [31:0] m, input logic [33:0] e);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      chk_reg(n, {1'b1, e}, {rvalid, rresp, rdata & m});
   endtask
   task wait_rails(input logic [3:0] v);
      int t;
      for (t = 0; t < 600; t++) begin
         @(posedge aclk);
         if (supply_en === v) break;
      end
      chk_pin("rails", v, supply_en);
   endtask
   task complete_run;
      if (error_cnt == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Whole run needs well under a thousand cycles
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         complete_run();
      end
   end
   // ----------------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------------
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      wait_rails(4'hf);
      chk_pin("reboot", 4'h1, host_reboot_n);
      chk_pin("irq", 4'h1, interrupt_request_n);
      rd("mask", `SUV_ADDR_MASK, 32'h1, 34'h0);
      rd("ctrl", `SUV_ADDR_CTRL, 32'h1, 34'h1);
      rd("retry", `SUV_ADDR_RETRY, 32'hf, 34'h0);
      rd("unmapped", 8'h40, 32'h0, {2'h2, 32'h0});
      wr(8'h40, 32'h1, 2'h2);
      // A write without its low byte strobe must leave the register alone
      wstrb <= 4'he;
      wr(`SUV_ADDR_CTRL, 32'h0, 2'h0);
      wstrb <= 4'hf;
      rd("ctrl", `SUV_ADDR_CTRL, 32'h1, 34'h1);
      rd("mode", `SUV_ADDR_STATUS, 32'h1f, 34'h4);
      level <= 2'h1;
      repeat (8) @(posedge aclk);
      chk_pin("irq", 4'h0, interrupt_request_n);
      level <= 2'h0;
      repeat (6) @(posedge aclk);
      chk_pin("irq", 4'h0, interrupt_request_n);
      rd("debounce", `SUV_ADDR_STATUS, 32'h10000, 34'h10000);
      rd("event", `SUV_ADDR_EVENT, 32'h1, 34'h1);
      repeat (3) @(posedge aclk);
      chk_pin("irq", 4'h1, interrupt_request_n);
      // A drop inside the debounce window must stay unseen
      level <= 2'h1;
      repeat (8) @(posedge aclk);
      level <= 2'h0;
      repeat (4) @(posedge aclk);
      rd("event", `SUV_ADDR_EVENT, 32'h1, 34'h0);
      chk_pin("irq", 4'h1, interrupt_request_n);
      repeat (40) @(posedge aclk);
      rd("debounce", `SUV_ADDR_STATUS, 32'h10000, 34'h0);
      wr(`SUV_ADDR_MASK, 32'h1, 2'h0);
      level <= 2'h1;
      repeat (8) @(posedge aclk);
      chk_pin("irq", 4'h1, interrupt_request_n);
      rd("event", `SUV_ADDR_EVENT, 32'h1, 34'h1);
      level <= 2'h0;
      wr(`SUV_ADDR_MASK, 32'h0, 2'h0);
      repeat (60) @(posedge aclk);
      wr(`SUV_ADDR_RETRY, 32'h5, 2'h0);
      level <= 2'h2;
      wait_rails(4'h0);
      chk_pin("reboot", 4'h0, host_reboot_n);
      rd("fault", `SUV_ADDR_FAULT, 32'h1, 34'h1);
      rd("retry", `SUV_ADDR_RETRY, 32'hf, 34'h0);
      rd("mode", `SUV_ADDR_STATUS, 32'h1f, 34'h1);
      repeat (30) @(posedge aclk);
      chk_pin("rails", 4'h0, supply_en);
      rd("fault", `SUV_ADDR_FAULT, 32'h1, 34'h1);
      level <= 2'h0;
      wait_rails(4'hf);
      chk_pin("reboot", 4'h1, host_reboot_n);
      wr(`SUV_ADDR_FAULT, 32'h1, 2'h0);
      rd("fault", `SUV_ADDR_FAULT, 32'h1, 34'h0);
      // Software power-down ends switched off, not in reset
      wr(`SUV_ADDR_CTRL, 32'h0, 2'h0);
      wait_rails(4'h0);
      rd("mode", `SUV_ADDR_STATUS, 32'h1f, 34'h10);
      wr(`SUV_ADDR_CTRL, 32'h1, 2'h0);
      wait_rails(4'hf);
      complete_run();
   end
endmodule // suv_supervisor_tb_top
